// ---- rtl/imu_regs_pkg.sv ----
// Purpose: shared constants for the inertial sensor register block
// Assumes: 125 MHz system clock, spi mode 3 link sampled by that clock
// Notes:   byte addresses are the printed register offsets
`default_nettype none
package imu_regs_pkg;
  // output register byte addresses (lower byte)
  localparam logic [6:0] ADDR_RATE_X   = 7'h04;
  localparam logic [6:0] ADDR_RATE_Y   = 7'h06;
  localparam logic [6:0] ADDR_RATE_Z   = 7'h08;
  localparam logic [6:0] ADDR_ACCEL_X  = 7'h0a;
  localparam logic [6:0] ADDR_ACCEL_Y  = 7'h0c;
  localparam logic [6:0] ADDR_ACCEL_Z  = 7'h0e;
  localparam logic [6:0] ADDR_TEMP     = 7'h18;
  // control registers
  localparam logic [6:0] ADDR_SAMPLE_PERIOD = 7'h36;
  localparam logic [6:0] ADDR_RANGE_FILTER  = 7'h38;
  localparam logic [6:0] ADDR_GLOBAL_CMD    = 7'h3e;
  localparam logic [6:0] ADDR_PRODUCT_CODE  = 7'h56;
  // reset values of the working copies
  localparam logic [15:0] RST_SAMPLE_PERIOD = 16'h0001;
  localparam logic [15:0] RST_RANGE_FILTER  = 16'h0402;
  // frame fields
  localparam int FRAME_BITS = 16;
  localparam int BIT_WRITE  = 15;
  localparam int CMD_BIT_BACKUP = 3;
  localparam int CMD_BIT_SWRESET = 7;
  localparam logic [7:0] SLOW_RATE_CODE = 8'h04;
  localparam int TEMP_BITS = 12;
  // timing
  localparam int CLK_HZ = 125_000_000;
  localparam int BACKUP_TIME_MS = 75;
  localparam int BACKUP_CYCLES = (CLK_HZ / 1000) * BACKUP_TIME_MS;
  // base sample divider at the default rate; slow mode is eight times longer
  localparam int SAMPLE_DIV_BASE = 152588;
  localparam int SLOW_FACTOR = 8;
endpackage : imu_regs_pkg
`default_nettype wire

// ---- rtl/imu_nv_store.sv ----
// Purpose: nonvolatile mirror of the two backed-up control registers
// Assumes: contents and valid flag survive rst_n (models flash)
// Notes:   read data come out of a register
`default_nettype none
module imu_nv_store (
  // clock
  input  wire logic        mclk,
  // write side
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_period,
  input  wire logic [15:0] wr_range,
  // read side
  output logic             rd_valid,
  output logic      [15:0] rd_period,
  output logic      [15:0] rd_range
);
  typedef struct packed {
    logic        valid;   // a backup has completed
    logic [15:0] period;  // stored sample period
    logic [15:0] range;   // stored range and filter
  } nv_t;
  nv_t mem;
  nv_t next_mem;
  // flash does not forget on reset, so no reset term here
  always_comb begin
    next_mem = mem;
    if (wr_en) begin
      next_mem = '{valid: 1'b1, period: wr_period, range: wr_range};
    end
  end
  always_ff @(posedge mclk) begin
    mem <= next_mem;
  end
  assign rd_valid  = mem.valid === 1'b1;
  assign rd_period = mem.period;
  assign rd_range  = mem.range;
endmodule : imu_nv_store
`default_nettype wire

// ---- rtl/imu_output_and_config_regs.sv ----
// Purpose: spi register port, output data registers and dual memory control
// Assumes: sclk idles high, 16-bit frames, sclk well below mclk/4
// Notes:   sensor samples arrive on parallel ports with a strobe
// Overview of operation
// - configuration written one byte per frame
// - registers 16 bits, low byte even address
// - write frame: bit15 set, address, data byte
// - period upper byte 0x04 slows sampling eightfold
// - writes change only the volatile working copy
// - command bit 3 backs up to nonvolatile
// - backup busy for 75 ms
// - reset reloads working copy from valid backup
// - rate registers 16-bit two's complement
// - acceleration registers 16-bit two's complement
// - temperature 12 bits, upper four read zero
// - each channel owns an output register
// - read answers during the following frame
// - spi mode 3, msb first, slave
// - command trigger bits self-clear when done
// - command bit 7 performs software reset
`default_nettype none
module imu_output_and_config_regs #(
  parameter int BACKUP_CYCLES = imu_regs_pkg::BACKUP_CYCLES,
  parameter int SAMPLE_DIV    = imu_regs_pkg::SAMPLE_DIV_BASE
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // spi pins
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        mosi,
  output logic             miso,
  output logic             miso_oe,
  // sensor samples from the processing chain
  input  wire logic        sample_valid,
  input  wire logic [15:0] rate_x,
  input  wire logic [15:0] rate_y,
  input  wire logic [15:0] rate_z,
  input  wire logic [15:0] accel_x,
  input  wire logic [15:0] accel_y,
  input  wire logic [15:0] accel_z,
  input  wire logic [11:0] temp,
  // status toward the rest of the device
  output logic             sample_tick,
  output logic             backup_busy
);
  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,  // reload working copy after reset
    ST_RUN  = 2'b01,  // normal operation
    ST_BACK = 2'b11   // backup in progress
  } mode_t;

  typedef struct packed {
    logic [1:0]  cs_s;       // synchroniser for cs_n
    logic [1:0]  sclk_s;     // synchroniser for sclk
    logic [1:0]  mosi_s;     // synchroniser for mosi
    logic        sclk_d;     // delayed synchronised sclk for edges
    logic [4:0]  bits;       // bits taken in this frame
    logic [15:0] rx;         // receive shift register
    logic [15:0] tx;         // transmit shift register
    logic [15:0] answer;     // word to send in the next frame
    logic        miso;       // registered pin output
    logic        miso_oe;    // registered pin enable
    logic [15:0] rate_x;     // output data registers
    logic [15:0] rate_y;
    logic [15:0] rate_z;
    logic [15:0] accel_x;
    logic [15:0] accel_y;
    logic [15:0] accel_z;
    logic [11:0] temp;
    logic [15:0] period;     // working copy of sample period
    logic [15:0] range;      // working copy of range and filter
    logic [7:0]  cmd;        // global command trigger bits
    mode_t       mode;
    logic [31:0] cnt;        // backup timer
    logic        nv_wr;      // write pulse to the mirror
    logic [31:0] div;        // sample divider counter
    logic        tick;       // one-cycle sample pulse
    logic        busy;       // registered backup busy, drives the pin
  } state_t;

  state_t st;
  state_t next_st;
  logic        nv_valid;
  logic [15:0] nv_period;
  logic [15:0] nv_range;

  // identification value, arbitrary
  localparam logic [15:0] PRODUCT_CODE = 16'h1234;

  // pick the 16-bit word for an address; an odd address reads the word at the even address below it
  function automatic logic [15:0] read_word(input state_t s, input logic [6:0] a);
    logic [15:0] w;
    w = 16'h0000;
    case ({a[6:1], 1'b0})
      imu_regs_pkg::ADDR_RATE_X:        w = s.rate_x;
      imu_regs_pkg::ADDR_RATE_Y:        w = s.rate_y;
      imu_regs_pkg::ADDR_RATE_Z:        w = s.rate_z;
      imu_regs_pkg::ADDR_ACCEL_X:       w = s.accel_x;
      imu_regs_pkg::ADDR_ACCEL_Y:       w = s.accel_y;
      imu_regs_pkg::ADDR_ACCEL_Z:       w = s.accel_z;
      imu_regs_pkg::ADDR_TEMP:          w = {4'h0, s.temp};
      imu_regs_pkg::ADDR_SAMPLE_PERIOD: w = s.period;
      imu_regs_pkg::ADDR_RANGE_FILTER:  w = s.range;
      imu_regs_pkg::ADDR_PRODUCT_CODE:  w = PRODUCT_CODE;
      default:                          w = 16'h0000;
    endcase
    return w;
  endfunction : read_word

  imu_nv_store nv (
    .mclk      (mclk),
    .wr_en     (st.nv_wr),
    .wr_period (st.period),
    .wr_range  (st.range),
    .rd_valid  (nv_valid),
    .rd_period (nv_period),
    .rd_range  (nv_range)
  );

  // all next-state logic
  always_comb begin
    logic        rise;
    logic        fall;
    logic [15:0] frame;
    logic [31:0] div_top;
    logic [7:0]  cmd_set;    // trigger bits written by this frame
    rise    = 1'b0;
    fall    = 1'b0;
    frame   = 16'h0000;
    div_top = 32'(SAMPLE_DIV);
    cmd_set = 8'h00;
    next_st = st;
    next_st.nv_wr = 1'b0;
    next_st.tick  = 1'b0;
    // pins pass two flops before use
    next_st.cs_s   = {st.cs_s[0], cs_n};
    next_st.sclk_s = {st.sclk_s[0], sclk};
    next_st.mosi_s = {st.mosi_s[0], mosi};
    next_st.sclk_d = st.sclk_s[1];
    rise = st.sclk_s[1] & ~st.sclk_d;
    fall = ~st.sclk_s[1] & st.sclk_d;
    next_st.miso_oe = ~st.cs_s[1];
    if (st.cs_s[1]) begin
      // deselected: restart frame, preload answer for next frame
      next_st.bits = 5'd0;
      next_st.tx   = st.answer;
    end else begin
      if (fall) begin
        // mode 3 shifts out on the falling edge, msb first
        next_st.miso = st.tx[15];
        next_st.tx   = {st.tx[14:0], 1'b0};
      end
      if (rise) begin
        // sample on the rising edge
        frame        = {st.rx[14:0], st.mosi_s[1]};
        next_st.rx   = frame;
        next_st.bits = st.bits + 5'd1;
        if (st.bits == 5'(imu_regs_pkg::FRAME_BITS - 1)) begin
          next_st.bits = 5'd0;
          if (frame[imu_regs_pkg::BIT_WRITE]) begin
            // one byte per write, parity of address picks lane
            case ({frame[14:9], 1'b0})
              imu_regs_pkg::ADDR_SAMPLE_PERIOD: begin
                if (frame[8]) next_st.period[15:8] = frame[7:0];
                else          next_st.period[7:0]  = frame[7:0];
              end
              imu_regs_pkg::ADDR_RANGE_FILTER: begin
                if (frame[8]) next_st.range[15:8] = frame[7:0];
                else          next_st.range[7:0]  = frame[7:0];
              end
              imu_regs_pkg::ADDR_GLOBAL_CMD: begin
                // merged after the mode logic so a new trigger beats a clear
                if (!frame[8]) cmd_set = frame[7:0];
              end
              default: ;
            endcase
            next_st.answer = 16'h0000;
          end else begin
            // capture whole word now so no later sample tears it
            next_st.answer = read_word(st, frame[14:8]);
          end
        end
      end
    end
    // sample timer, slowed by eight on code 0x04
    if (st.period[15:8] == imu_regs_pkg::SLOW_RATE_CODE) begin
      div_top = 32'(SAMPLE_DIV * imu_regs_pkg::SLOW_FACTOR);
    end
    if (st.div >= div_top - 32'd1) begin
      next_st.div  = 32'd0;
      next_st.tick = 1'b1;
    end else begin
      next_st.div = st.div + 32'd1;
    end
    // newest sample loads each channel register
    if (sample_valid) begin
      next_st.rate_x  = rate_x;
      next_st.rate_y  = rate_y;
      next_st.rate_z  = rate_z;
      next_st.accel_x = accel_x;
      next_st.accel_y = accel_y;
      next_st.accel_z = accel_z;
      next_st.temp    = temp;
    end
    // mode sequencing
    case (st.mode)
      ST_LOAD: begin
        if (nv_valid) begin
          next_st.period = nv_period;
          next_st.range  = nv_range;
        end
        next_st.mode = ST_RUN;
      end
      ST_RUN: begin
        if (st.cmd[imu_regs_pkg::CMD_BIT_SWRESET]) begin
          // software reset: restore defaults then reload mirror
          next_st.period = imu_regs_pkg::RST_SAMPLE_PERIOD;
          next_st.range  = imu_regs_pkg::RST_RANGE_FILTER;
          next_st.cmd    = 8'h00;
          next_st.mode   = ST_LOAD;
        end else if (st.cmd[imu_regs_pkg::CMD_BIT_BACKUP]) begin
          // mirror is written only once the busy time has run out
          next_st.cnt   = 32'd0;
          next_st.mode  = ST_BACK;
        end
        next_st.cmd[6:4] = 3'b000;
        next_st.cmd[2:0] = 3'b000;
      end
      ST_BACK: begin
        next_st.cnt = st.cnt + 32'd1;
        if (st.cnt >= 32'(BACKUP_CYCLES) - 32'd1) begin
          next_st.cmd[imu_regs_pkg::CMD_BIT_BACKUP] = 1'b0;
          // a reset inside the busy time leaves the old mirror intact
          next_st.nv_wr = 1'b1;
          next_st.mode = ST_RUN;
        end
      end
      default: next_st.mode = ST_RUN;
    endcase
    // a trigger written in the cycle of a clear still lands
    next_st.cmd  = next_st.cmd | cmd_set;
    // busy comes from a flop so the pin never glitches on decode
    next_st.busy = (next_st.mode == ST_BACK);
  end

  // single state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st        <= '0;
      st.cs_s   <= 2'b11;
      st.sclk_s <= 2'b11;
      st.sclk_d <= 1'b1;
      st.period <= imu_regs_pkg::RST_SAMPLE_PERIOD;
      st.range  <= imu_regs_pkg::RST_RANGE_FILTER;
      st.mode   <= ST_LOAD;
    end else begin
      st <= next_st;
    end
  end

  assign miso        = st.miso;
  assign miso_oe     = st.miso_oe;
  assign sample_tick = st.tick;
  assign backup_busy = st.busy;

  // backup holds busy for the full count once started
  a_backup_length: assert property (@(posedge mclk) disable iff (!rst_n)
    (st.mode == ST_BACK && st.cnt < 32'(BACKUP_CYCLES) - 32'd1) |=> st.mode == ST_BACK)
    else $error("backup ended too soon");
  // busy starts with the timer at zero, so the full count is served
  a_backup_count: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(backup_busy) |-> st.cnt == 32'd0)
    else $error("backup timer not cleared at start");
  // mirror written only when backup completes
  a_mirror_write: assert property (@(posedge mclk) disable iff (!rst_n)
    st.nv_wr |-> $past(st.mode) == ST_BACK && st.mode == ST_RUN)
    else $error("mirror written outside backup end");
  // backup command leads to backup next cycle
  a_backup_start: assert property (@(posedge mclk) disable iff (!rst_n)
    (st.mode == ST_RUN && st.cmd[3] && !st.cmd[7]) |=> st.mode == ST_BACK)
    else $error("backup did not start");
  // software reset goes through reload
  a_swreset_load: assert property (@(posedge mclk) disable iff (!rst_n)
    (st.mode == ST_RUN && st.cmd[7]) |=> st.mode == ST_LOAD ##1 st.mode == ST_RUN)
    else $error("software reset skipped reload");
  // a latched temperature answer carries zeros above the 12-bit field
  a_temp_upper: assert property (@(posedge mclk) disable iff (!rst_n)
    ($changed(st.rx) && st.bits == 5'd0 && !st.rx[imu_regs_pkg::BIT_WRITE] &&
     st.rx[14:9] == imu_regs_pkg::ADDR_TEMP[6:1]) |-> st.answer[15:12] == 4'h0)
    else $error("temperature upper bits nonzero");
  // pin enable follows synchronised select
  a_miso_enable: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(st.cs_s[1]) |=> miso_oe)
    else $error("miso not enabled on select");
  // new sample lands in the rate register
  a_sample_load: assert property (@(posedge mclk) disable iff (!rst_n)
    sample_valid |=> st.rate_x == $past(rate_x) && st.accel_z == $past(accel_z))
    else $error("sample not loaded");
  // reload takes the mirror when valid
  a_reload_mirror: assert property (@(posedge mclk) disable iff (!rst_n)
    (st.mode == ST_LOAD && nv_valid) |=> st.range == $past(nv_range))
    else $error("working copy not reloaded");
endmodule : imu_output_and_config_regs
`default_nettype wire

// ---- test/spi_master_model.sv ----
// Purpose: spi master standing in for the host processor
// Assumes: mode 3, 125 ns bit period, 16-bit frames
// Notes:   sclk rests high between frames; mosi never shows stale data there
`default_nettype none
module spi_master_model (
  // spi pins
  output var logic cs_n,
  output var logic sclk,
  output var logic mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus: deselected, clock parked high
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    mosi = 1'b0;
  end
  // one frame; gap_ns sets how promptly the next frame may follow
  task automatic xfer(input logic [15:0] tx, input int gap_ns, output logic [15:0] rx);
    cs_n = 1'b0;
    #62.5;
    for (int i = 15; i >= 0; i--) begin // msb first
      sclk = 1'b0;
      mosi = tx[i]; // write flag, address, data byte
      #62.5;
      sclk = 1'b1;
      rx[i] = miso; // sampled on the second edge
      #62.5;
    end
    cs_n = 1'b1;
    // released line: invert so a held value cannot pass for data
    mosi = ~mosi;
    #(gap_ns);
  endtask : xfer
endmodule : spi_master_model
`default_nettype wire

// ---- test/testbench.sv ----
// Purpose: self-checking bench for the sensor register block
// Assumes: short backup and sample divider parameters
// Notes:   every register access goes over the spi model
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BACKUP_CYC = 50; // shortened backup time
  localparam int DIV        = 20; // shortened sample divider
  logic        mclk, rst_n, cs_n, sclk, mosi, miso, miso_oe;
  logic        sample_valid, sample_tick, backup_busy;
  logic [15:0] smp [7];           // rate x/y/z, accel x/y/z, temp
  int          bad_count = 0, checks_done = 0;
  int          cyc = 0, tick_last = 0, tick_gap = 0, busy_cnt = 0;
  logic        miso_line;         // data line as the host sees it

  imu_output_and_config_regs #(.BACKUP_CYCLES(BACKUP_CYC), .SAMPLE_DIV(DIV)) DUT (
    .mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .sample_valid(sample_valid),
    .rate_x(smp[0]), .rate_y(smp[1]), .rate_z(smp[2]), .accel_x(smp[3]),
    .accel_y(smp[4]), .accel_z(smp[5]), .temp(smp[6][11:0]),
    .sample_tick(sample_tick), .backup_busy(backup_busy));
  // an undriven line shows the inverse, so a missing enable corrupts reads
  assign miso_line = (miso_oe === 1'b1) ? miso : ~miso;
  spi_master_model master (.cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso_line));

  // clock generator
  always #4 mclk = ~mclk;
  // tick spacing and busy length, counted at the rising edge
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (sample_tick === 1'b1) begin
      tick_gap  <= cyc - tick_last;
      tick_last <= cyc;
    end
    if (backup_busy === 1'b1) busy_cnt <= busy_cnt + 1;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // read takes a request frame, then the answer frame
  task automatic rdchk(input string what, input logic [6:0] addr, input logic [15:0] exp);
    logic [15:0] d;
    master.xfer({1'b0, addr, 8'h00}, 500, d);
    master.xfer(16'h0000, 500, d);
    chk(what, exp, d);
  endtask : rdchk
  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    logic [15:0] d;
    master.xfer({1'b1, addr, data}, 500, d);
  endtask : wr
  task automatic pulse_sample();
    @(negedge mclk) sample_valid = 1'b1;
    @(negedge mclk) sample_valid = 1'b0;
  endtask : pulse_sample
  // reset held ten cycles; frames wait a few cycles after release
  task automatic do_reset();
    @(negedge mclk) rst_n = 1'b0;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    repeat (5) @(negedge mclk);
    chk("miso_oe idle", 16'h0000, {15'h0000, miso_oe});
  endtask : do_reset

  task automatic t_defaults();
    rdchk("period default", 7'h36, 16'h0001);
    rdchk("range default", 7'h38, 16'h0402);
    rdchk("unmapped", 7'h10, 16'h0000);
    rdchk("product code", 7'h56, 16'h1234);
    $display("test defaults done");
  endtask : t_defaults
  // positive and negative two's complement codes; temp upper nibble driven high
  task automatic t_outputs();
    logic [15:0] v [7] = '{16'h61a8, 16'hffff, 16'h9e58, 16'h4e20, 16'hfffe, 16'hb1e0,
                           16'h0c3e};
    logic [6:0]  a [7] = '{7'h04, 7'h06, 7'h08, 7'h0a, 7'h0c, 7'h0e, 7'h18};
    @(negedge mclk);
    smp = v;
    smp[6] = 16'hfc3e;
    pulse_sample();
    foreach (a[i]) rdchk("output reg", a[i], v[i]);
    rdchk("odd byte addr", 7'h05, v[0]);
    wr(7'h04, 8'h55);
    rdchk("read-only kept", 7'h04, v[0]);
    $display("test outputs done");
  endtask : t_outputs
  // new sample lands mid answer frame; the word must stay whole
  task automatic t_tear();
    logic [15:0] d;
    logic [15:0] got;
    master.xfer(16'h0400, 100, d);
    fork
      master.xfer(16'h0000, 100, got);
      begin
        repeat (130) @(negedge mclk);
        smp[0] = 16'h1357;
        pulse_sample();
      end
    join
    chk("no tear", 16'h61a8, got);
    rdchk("new sample", 7'h04, 16'h1357);
    $display("test tear done");
  endtask : t_tear
  // single byte writes, then slow sampling
  task automatic t_write();
    int          g0;
    logic [15:0] d;
    repeat (DIV * 3) @(negedge mclk);
    g0 = tick_gap;
    chk("default tick gap", 16'(DIV), 16'(g0));
    wr(7'h37, 8'h04);
    master.xfer(16'h0000, 500, d);
    chk("answer after write", 16'h0000, d);
    repeat (DIV * 8 * 3) @(negedge mclk);
    chk("slow tick gap", 16'(g0 * 8), 16'(tick_gap));
    rdchk("period upper byte", 7'h36, 16'h0401);
    wr(7'h38, 8'h05);
    rdchk("range lower byte", 7'h38, 16'h0405);
    $display("test write done");
  endtask : t_write
  // backup, volatile edit, then hardware and software reset restore
  task automatic t_backup();
    int b0;
    @(negedge mclk) b0 = busy_cnt;
    wr(7'h3e, 8'h08);
    repeat (BACKUP_CYC + 100) @(negedge mclk);
    chk("busy length", 16'(BACKUP_CYC), 16'(busy_cnt - b0));
    wr(7'h37, 8'h00);
    rdchk("volatile edit", 7'h36, 16'h0001);
    do_reset();
    rdchk("period restored", 7'h36, 16'h0401);
    rdchk("range restored", 7'h38, 16'h0405);
    wr(7'h37, 8'h00);
    wr(7'h3e, 8'h80);
    repeat (20) @(negedge mclk);
    rdchk("soft reset restore", 7'h36, 16'h0401);
    $display("test backup done");
  endtask : t_backup

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // main sequence
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    sample_valid = 1'b0;
    smp = '{default: 16'h0000};
    do_reset();
    t_defaults();
    t_outputs();
    t_tear();
    t_write();
    t_backup();
    test_done();
  end
  // watchdog: about four and a half times the expected run
  initial begin
    #600000;
    bad_count++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
